//--- design/epi_irq_ctrl.sv
/*
 * External and pin-change interrupt controller with AXI4-Lite registers.
 * Assumes all pins are asynchronous to aclk and that the core pulses an
 * acknowledge per vector when it enters the matching handler.
 */
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps

module epi_irq_ctrl
    import epi_pkg::*;
#(
    parameter int GROUP_W = 8
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins
    input wire logic ext_irq_line_a,
    input wire logic ext_irq_line_b,
    input wire logic [GROUP_W-1:0] lower_group_pins,
    input wire logic [GROUP_W-1:0] upper_group_pins,
    // Core side
    input wire logic cpu_global_ie,
    input wire logic ack_ext_a,
    input wire logic ack_ext_b,
    input wire logic ack_lower_group,
    input wire logic ack_upper_group,
    output logic req_ext_a,
    output logic req_ext_b,
    output logic req_lower_group,
    output logic req_upper_group
);

    // Register file fields are byte wide, so at most eight pins per group
    // can be served; wider groups are refused when the design is built,
    // not discovered later as silently dropped mask bits
    if (GROUP_W < 1 || GROUP_W > 8) begin : g_bad_group_w
        $error("GROUP_W must be 1 to 8");
    end

    // Software-visible register state, narrowed to the bits that exist
    logic [3:0] sense_q; // Sense control {b_hi,b_lo,a_hi,a_lo}
    logic [1:0] emask_q; // External line enables
    logic [1:0] eflag_q; // External line flags
    logic [1:0] gen_q; // Group enables
    logic [1:0] pflag_q; // Group flags
    logic [GROUP_W-1:0] pmsku_q; // Upper pin masks
    logic [GROUP_W-1:0] pmskl_q; // Lower pin masks

    // Synchronisers: stage one read only by stage two
    // Stage three keeps the previous settled sample; edges are judged
    // between stages two and three only, never on a raw pin
    logic [1:0] ext_s1_q;
    logic [1:0] ext_s2_q;
    logic [1:0] ext_s3_q; // Previous synchronised value
    logic [GROUP_W-1:0] lo_s1_q, lo_s2_q, lo_s3_q;
    logic [GROUP_W-1:0] up_s1_q, up_s2_q, up_s3_q;
    logic gie_s1_q, gie_s2_q;

    // Bus state
    epi_wstate_t wstate_q;
    logic aw_got_q, w_got_q;
    logic [11:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_fire; // Write committed this cycle
    logic wr_hit; // Write address decodes to a register
    logic [1:0] eflag_w1c, pflag_w1c; // Software clear strobes

    // Pin synchronisers (pins live in another domain)
    // The global enable comes from the core's own timing, so it is treated as a pin
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // External lines rest high; resetting to that level keeps a
            // false edge or level request from following reset
            ext_s1_q <= 2'h3;
            ext_s2_q <= 2'h3;
            ext_s3_q <= 2'h3;
            lo_s1_q <= '0;
            lo_s2_q <= '0;
            lo_s3_q <= '0;
            up_s1_q <= '0;
            up_s2_q <= '0;
            up_s3_q <= '0;
            gie_s1_q <= 1'b0;
            gie_s2_q <= 1'b0;
        end else begin
            ext_s1_q <= {ext_irq_line_b, ext_irq_line_a};
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
            lo_s1_q <= lower_group_pins;
            lo_s2_q <= lo_s1_q;
            lo_s3_q <= lo_s2_q;
            up_s1_q <= upper_group_pins;
            up_s2_q <= up_s1_q;
            up_s3_q <= up_s2_q;
            gie_s1_q <= cpu_global_ie;
            gie_s2_q <= gie_s1_q;
        end
    end

    // Edge events on the synchronised external lines
    // Level mode raises no event: it feeds the request directly, so the
    // flag can stay clear while the line is level sensed
    logic [1:0] ext_hit;
    logic [1:0] ext_level;
    always_comb begin
        ext_hit = 2'h0;
        ext_level = 2'h0;
        for (int i = 0; i < 2; i++) begin
            case (sense_q[2*i +: 2])
                EPI_SNS_LOW: ext_level[i] = ~ext_s2_q[i];
                EPI_SNS_ANY: ext_hit[i] = ext_s2_q[i] ^ ext_s3_q[i];
                EPI_SNS_FALL: ext_hit[i] = ext_s3_q[i] & ~ext_s2_q[i];
                EPI_SNS_RISE: ext_hit[i] = ~ext_s3_q[i] & ext_s2_q[i];
                default: ext_hit[i] = 1'b0;
            endcase
        end
    end

    // Group change events through per-pin masks
    // A pin counts only while its mask bit and its group enable are both
    // set; a change seen with the group off is dropped, not held back
    logic lo_hit, up_hit;
    assign lo_hit = gen_q[EPI_BIT_LOWER] & |((lo_s2_q ^ lo_s3_q) & pmskl_q);
    assign up_hit = gen_q[EPI_BIT_UPPER] & |((up_s2_q ^ up_s3_q) & pmsku_q);

    // External flags: set wins over clears; level mode forces zero
    // A pin event in the same cycle as a software clear or a handler
    // entry is kept, so no edge is lost between the two
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            eflag_q <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (sense_q[2*i +: 2] == EPI_SNS_LOW) begin
                    eflag_q[i] <= 1'b0;
                end else if (ext_hit[i]) begin
                    eflag_q[i] <= 1'b1;
                end else if (eflag_w1c[i] || (i == 0 ? ack_ext_a : ack_ext_b)) begin
                    eflag_q[i] <= 1'b0;
                end
            end
        end
    end

    // Group flags: set wins over clears
    // Same priority as the line flags: a late change re-arms the flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pflag_q <= 2'h0;
        end else begin
            if (lo_hit) begin
                pflag_q[EPI_BIT_LOWER] <= 1'b1;
            end else if (pflag_w1c[EPI_BIT_LOWER] || ack_lower_group) begin
                pflag_q[EPI_BIT_LOWER] <= 1'b0;
            end
            if (up_hit) begin
                pflag_q[EPI_BIT_UPPER] <= 1'b1;
            end else if (pflag_w1c[EPI_BIT_UPPER] || ack_upper_group) begin
                pflag_q[EPI_BIT_UPPER] <= 1'b0;
            end
        end
    end

    // Request outputs to the core
    // Registered so the core sees clean levels; the global enable comes
    // through its own two-flop synchroniser, so it lags two cycles
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_ext_a <= 1'b0;
            req_ext_b <= 1'b0;
            req_lower_group <= 1'b0;
            req_upper_group <= 1'b0;
        end else begin
            // Level mode requests while pin is low
            req_ext_a <= gie_s2_q & emask_q[EPI_BIT_A]
                & (eflag_q[EPI_BIT_A] | ext_level[EPI_BIT_A]);
            req_ext_b <= gie_s2_q & emask_q[EPI_BIT_B]
                & (eflag_q[EPI_BIT_B] | ext_level[EPI_BIT_B]);
            req_lower_group <= gie_s2_q & gen_q[EPI_BIT_LOWER]
                & pflag_q[EPI_BIT_LOWER];
            req_upper_group <= gie_s2_q & gen_q[EPI_BIT_UPPER]
                & pflag_q[EPI_BIT_UPPER];
        end
    end

    // Write channel capture: address and data in either order
    // Each ready pulses for one cycle after its valid is seen, then stays
    // low until the response is taken; one write is under way at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wstate_q <= EPI_W_IDLE;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= 12'h000;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= EPI_RESP_OKAY;
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            case (wstate_q)
                EPI_W_IDLE: begin
                    // Ready pulses one cycle when valid seen
                    if (s_axi_awvalid && !aw_got_q && !s_axi_awready) begin
                        s_axi_awready <= 1'b1;
                    end
                    if (s_axi_awvalid && s_axi_awready) begin
                        aw_got_q <= 1'b1;
                        awaddr_q <= s_axi_awaddr;
                    end
                    if (s_axi_wvalid && !w_got_q && !s_axi_wready) begin
                        s_axi_wready <= 1'b1;
                    end
                    if (s_axi_wvalid && s_axi_wready) begin
                        w_got_q <= 1'b1;
                        wdata_q <= s_axi_wdata;
                        wstrb_q <= s_axi_wstrb;
                    end
                    if (wr_fire) begin
                        wstate_q <= EPI_W_RESP;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp <= wr_hit ? EPI_RESP_OKAY : EPI_RESP_SLVERR;
                    end
                end
                EPI_W_RESP: begin
                    // Hold response until accepted
                    if (s_axi_bready) begin
                        s_axi_bvalid <= 1'b0;
                        aw_got_q <= 1'b0;
                        w_got_q <= 1'b0;
                        wstate_q <= EPI_W_IDLE;
                    end
                end
                default: wstate_q <= EPI_W_IDLE;
            endcase
        end
    end

    // Commit when both halves held
    // Unmapped addresses answer with an error and change nothing; the
    // read-only status word answers OKAY and ignores the data
    logic wb0; // Low byte lane written this cycle
    assign wr_fire = (wstate_q == EPI_W_IDLE) && aw_got_q && w_got_q;
    assign wb0 = wr_fire && wstrb_q[0];
    always_comb begin
        case (awaddr_q & 12'hffc)
            EPI_OFS_SENSE, EPI_OFS_EMASK, EPI_OFS_EFLAG, EPI_OFS_GEN,
            EPI_OFS_PFLAG, EPI_OFS_PMSKU, EPI_OFS_PMSKL, EPI_OFS_CPU: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end
    assign eflag_w1c = (wb0 && (awaddr_q & 12'hffc) == EPI_OFS_EFLAG) ? wdata_q[1:0] : 2'h0;
    assign pflag_w1c = (wb0 && (awaddr_q & 12'hffc) == EPI_OFS_PFLAG) ? wdata_q[1:0] : 2'h0;

    // Control registers written by software
    // Only the low byte lane carries register bits; other lanes are
    // ignored, so a write without the low strobe changes nothing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sense_q <= EPI_RST_SENSE;
            emask_q <= 2'h0;
            gen_q <= 2'h0;
            pmsku_q <= '0;
            pmskl_q <= '0;
        end else if (wb0) begin
            case (awaddr_q & 12'hffc)
                EPI_OFS_SENSE: sense_q <= wdata_q[3:0];
                EPI_OFS_EMASK: emask_q <= wdata_q[1:0];
                EPI_OFS_GEN: gen_q <= wdata_q[1:0];
                EPI_OFS_PMSKU: pmsku_q <= wdata_q[GROUP_W-1:0];
                EPI_OFS_PMSKL: pmskl_q <= wdata_q[GROUP_W-1:0];
                default: sense_q <= sense_q;
            endcase
        end
    end

    // Read data mux; unused bits zero
    // Decoded from the address while it is offered; the master holds it
    // until the address is taken, so the captured word is consistent
    logic [7:0] rd_byte;
    logic rd_hit;
    always_comb begin
        rd_byte = EPI_RST_BYTE;
        rd_hit = 1'b1;
        case (s_axi_araddr & 12'hffc)
            EPI_OFS_SENSE: rd_byte = {4'h0, sense_q};
            EPI_OFS_EMASK: rd_byte = {6'h00, emask_q};
            EPI_OFS_EFLAG: rd_byte = {6'h00, eflag_q};
            EPI_OFS_GEN: rd_byte = {6'h00, gen_q};
            EPI_OFS_PFLAG: rd_byte = {6'h00, pflag_q};
            EPI_OFS_PMSKU: rd_byte[GROUP_W-1:0] = pmsku_q;
            EPI_OFS_PMSKL: rd_byte[GROUP_W-1:0] = pmskl_q;
            EPI_OFS_CPU: rd_byte = {7'h00, gie_s2_q};
            default: rd_hit = 1'b0;
        endcase
    end

    // Read channel: accept, answer next cycle, hold until taken
    // No new address is taken while an answer waits, so data never stacks
    // and a slow master cannot lose a read word
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= EPI_RESP_OKAY;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_rvalid) begin
                if (s_axi_rready) begin
                    s_axi_rvalid <= 1'b0;
                end
            end else if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rd_byte};
                s_axi_rresp <= rd_hit ? EPI_RESP_OKAY : EPI_RESP_SLVERR;
            end else if (s_axi_arvalid) begin
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule : epi_irq_ctrl

//--- include/epi_pkg.sv
/*
 * Package for the external and pin-change interrupt block: register offsets,
 * field positions, reset values and sense-control encodings.
 * Assumes a 32-bit AXI4-Lite register bus, one aligned word per register.
 */
package epi_pkg;

    // Register byte offsets
    localparam logic [11:0] EPI_OFS_SENSE = 12'h000;
    localparam logic [11:0] EPI_OFS_EMASK = 12'h004;
    localparam logic [11:0] EPI_OFS_EFLAG = 12'h008;
    localparam logic [11:0] EPI_OFS_GEN = 12'h00c;
    localparam logic [11:0] EPI_OFS_PFLAG = 12'h010;
    localparam logic [11:0] EPI_OFS_PMSKU = 12'h014;
    localparam logic [11:0] EPI_OFS_PMSKL = 12'h018;
    localparam logic [11:0] EPI_OFS_CPU = 12'h01c;

    // Field positions
    localparam int EPI_BIT_A = 0;
    localparam int EPI_BIT_B = 1;
    localparam int EPI_BIT_LOWER = 0;
    localparam int EPI_BIT_UPPER = 1;

    // Reset values
    localparam logic [7:0] EPI_RST_BYTE = 8'h00;
    localparam logic [3:0] EPI_RST_SENSE = 4'h0;

    // Sense-control encodings
    localparam logic [1:0] EPI_SNS_LOW = 2'h0;
    localparam logic [1:0] EPI_SNS_ANY = 2'h1;
    localparam logic [1:0] EPI_SNS_FALL = 2'h2;
    localparam logic [1:0] EPI_SNS_RISE = 2'h3;

    // AXI response codes
    localparam logic [1:0] EPI_RESP_OKAY = 2'h0;
    localparam logic [1:0] EPI_RESP_SLVERR = 2'h2;

    // Bus write state
    typedef enum logic [1:0] {
        EPI_W_IDLE,
        EPI_W_RESP
    } epi_wstate_t;

endpackage : epi_pkg

//--- tb/epi_core_model.sv
/* Core model: enters the handler of the lowest pending request.
   Assumes requests are levels on {upper, lower, b, a}. */
`timescale 1ns/1ps
module epi_core_model #(
    parameter int DLY = 3
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Handler entry allowed
    input wire logic take_en,
    // Requests and acknowledges
    input wire logic [3:0] req,
    output logic [3:0] ack
);
    int cnt_q; // Latency before handler entry
    logic [3:0] ack_q; // One-cycle handler entry pulse
    assign ack = ack_q;
    // Waits DLY+1 cycles on a pending request, then acks one source
    always_ff @(posedge aclk) begin
        if (!aresetn || !take_en || req == 4'h0 || ack_q != 4'h0) begin
            cnt_q <= 0;
            ack_q <= 4'h0;
        end else if (cnt_q == DLY) begin
            ack_q <= req & (~req + 4'h1);
            cnt_q <= 0;
        end else begin
            cnt_q <= cnt_q + 1;
        end
    end
endmodule : epi_core_model

//--- tb/epi_irq_asserts.sv
/* Port checker for the interrupt controller.
   Bound to every controller instance; sees its ports only. */
`timescale 1ns/1ps
module epi_irq_asserts #(
    parameter int GROUP_W = 8
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Read data
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    // Pins and core side
    input wire logic [GROUP_W-1:0] lower_group_pins,
    input wire logic [GROUP_W-1:0] upper_group_pins,
    input wire logic cpu_global_ie,
    input wire logic ack_lower_group,
    input wire logic ack_upper_group,
    input wire logic req_ext_a,
    input wire logic req_ext_b,
    input wire logic req_lower_group,
    input wire logic req_upper_group
);
    // One domain, one reset
    default clocking dcb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    chk_ie_gates_a: assert property (!cpu_global_ie [*5] |=> !req_ext_a)
        else $error("line a request without global enable");
    chk_ie_gates_b: assert property (!cpu_global_ie [*5] |=> !req_ext_b)
        else $error("line b request without global enable");
    chk_ie_gates_low: assert property (!cpu_global_ie [*5] |=> !req_lower_group)
        else $error("lower group request without global enable");
    chk_ie_gates_up: assert property (!cpu_global_ie [*5] |=> !req_upper_group)
        else $error("upper group request without global enable");
    chk_reset_quiet: assert property ($rose(aresetn) |->
        !(req_ext_a || req_ext_b || req_lower_group || req_upper_group))
        else $error("request present after reset");
    chk_rd_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("unused read bits not zero");
    chk_ack_clr_up: assert property ($stable(upper_group_pins) [*6]
        ##1 ($stable(upper_group_pins) && ack_upper_group)
        ##1 $stable(upper_group_pins) [*4] |=> !req_upper_group)
        else $error("upper group request kept after handler entry");
    chk_ack_clr_low: assert property ($stable(lower_group_pins) [*6]
        ##1 ($stable(lower_group_pins) && ack_lower_group)
        ##1 $stable(lower_group_pins) [*4] |=> !req_lower_group)
        else $error("lower group request kept after handler entry");
endmodule : epi_irq_asserts

bind epi_irq_ctrl epi_irq_asserts #(.GROUP_W(GROUP_W)) epi_irq_asserts_i (.aclk, .aresetn,
    .s_axi_rdata, .s_axi_rvalid, .lower_group_pins, .upper_group_pins, .cpu_global_ie,
    .ack_lower_group, .ack_upper_group, .req_ext_a, .req_ext_b, .req_lower_group,
    .req_upper_group);

//--- tb/tb_top.sv
/* Self-checking bench for the interrupt controller and core model.
   Assumes the package offsets and a 50 MHz aclk. */
`timescale 1ns/1ps
module tb_top
    import epi_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic ext_irq_line_a = 1'b1, ext_irq_line_b = 1'b1, cpu_global_ie = 1'b0;
    logic [7:0] lower_group_pins = 8'h00, upper_group_pins = 8'h00;
    logic ack_ext_a, ack_ext_b, ack_lower_group, ack_upper_group;
    logic req_ext_a, req_ext_b, req_lower_group, req_upper_group;
    logic take_en = 1'b0;
    logic [3:0] req, ack;
    int error_cnt = 0, n_compared = 0;
    logic [33:0] rq [$]; // Expected {resp, data} of reads
    logic [1:0] wq [$]; // Expected write responses
    logic [31:0] rnd = 32'd35491;
    logic [7:0] mu, ml;
    logic [11:0] ofs [7] = '{EPI_OFS_SENSE, EPI_OFS_EMASK, EPI_OFS_GEN, EPI_OFS_PMSKU,
        EPI_OFS_PMSKL, EPI_OFS_EFLAG, EPI_OFS_PFLAG};
    logic [31:0] msk [7] = '{32'hf, 32'h3, 32'h3, 32'hff, 32'hff, 32'h0, 32'h0};
    assign req = {req_upper_group, req_lower_group, req_ext_b, req_ext_a};
    assign {ack_upper_group, ack_lower_group, ack_ext_b, ack_ext_a} = ack;

    epi_irq_ctrl epi_irq_ctrl_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .ext_irq_line_a, .ext_irq_line_b, .lower_group_pins, .upper_group_pins,
        .cpu_global_ie, .ack_ext_a, .ack_ext_b, .ack_lower_group, .ack_upper_group,
        .req_ext_a, .req_ext_b, .req_lower_group, .req_upper_group);
    epi_core_model epi_core_model_i (.aclk, .aresetn, .take_en, .req, .ack);

    // Clock, 20 ns period
    initial begin
        forever #10 aclk = ~aclk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Write with both channels offered together
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] r = EPI_RESP_OKAY);
        logic aw, w;
        @(posedge aclk);
        wq.push_back(r);
        aw = 1'b0;
        w = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1 && !aw) begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready === 1'b1 && !w) begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1) @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] r = EPI_RESP_OKAY);
        @(posedge aclk);
        rq.push_back({r, d});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask : rd

    // Drive one external line, held well over a clock
    task automatic pin(input int ln, input logic v);
        @(posedge aclk);
        if (ln == 0) ext_irq_line_a <= v;
        else ext_irq_line_b <= v;
        repeat (8) @(posedge aclk);
    endtask : pin

    task automatic tally_and_finish();
        $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish

    // Response monitor takes the oldest note
    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready) chk("read", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
        if (s_axi_bvalid && s_axi_bready) chk("bresp", {32'h0, wq.pop_front()}, {32'h0, s_axi_bresp});
    end

    // Watchdog
    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        tally_and_finish();
    end

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        // Reset values, access and unused bits
        foreach (ofs[k]) begin
            rd(ofs[k], 32'h0);
            rnd = xs(rnd);
            wr(ofs[k], rnd);
            rd(ofs[k], rnd & msk[k]);
            wr(ofs[k], 32'hffffffff);
            rd(ofs[k], msk[k]);
        end
        rd(EPI_OFS_CPU, 32'h0);
        wr(12'h020, 32'h1, EPI_RESP_SLVERR);
        rd(12'h020, 32'h0, EPI_RESP_SLVERR);
        // Every sense mode on both lines
        for (int ln = 0; ln < 2; ln++) begin
            for (int m = 0; m < 4; m++) begin
                wr(EPI_OFS_SENSE, 32'(m) << (2 * ln));
                wr(EPI_OFS_EFLAG, 32'h3);
                pin(ln, 1'b0);
                rd(EPI_OFS_EFLAG, (m == EPI_SNS_ANY || m == EPI_SNS_FALL) ? 32'h1 << ln : 32'h0);
                wr(EPI_OFS_EFLAG, 32'h0);
                rd(EPI_OFS_EFLAG, (m == EPI_SNS_ANY || m == EPI_SNS_FALL) ? 32'h1 << ln : 32'h0);
                wr(EPI_OFS_EFLAG, 32'h3);
                pin(ln, 1'b1);
                rd(EPI_OFS_EFLAG, (m == EPI_SNS_ANY || m == EPI_SNS_RISE) ? 32'h1 << ln : 32'h0);
            end
        end
        // Pin-change groups with random masks
        rnd = xs(rnd);
        mu = {rnd[7:2], 2'b01};
        ml = {rnd[15:10], 2'b10};
        wr(EPI_OFS_GEN, 32'h3);
        wr(EPI_OFS_PMSKU, {24'h0, mu});
        wr(EPI_OFS_PMSKL, {24'h0, ml});
        for (int i = 0; i < 8; i++) begin
            wr(EPI_OFS_PFLAG, 32'h3);
            @(posedge aclk);
            upper_group_pins <= upper_group_pins ^ (8'h1 << i);
            lower_group_pins <= lower_group_pins ^ (8'h1 << i);
            repeat (8) @(posedge aclk);
            rd(EPI_OFS_PFLAG, {30'h0, mu[i], ml[i]});
        end
        // Group enables off: unmasked changes must not set the flags
        wr(EPI_OFS_GEN, 32'h0);
        wr(EPI_OFS_PFLAG, 32'h3);
        upper_group_pins <= ~upper_group_pins;
        lower_group_pins <= ~lower_group_pins;
        repeat (8) @(posedge aclk);
        rd(EPI_OFS_PFLAG, 32'h0);
        wr(EPI_OFS_GEN, 32'h3);
        // Requests, gating and handler entry
        wr(EPI_OFS_SENSE, {28'h0, EPI_SNS_FALL, EPI_SNS_FALL});
        wr(EPI_OFS_EMASK, 32'h3);
        wr(EPI_OFS_PMSKU, 32'hff);
        wr(EPI_OFS_PMSKL, 32'hff);
        wr(EPI_OFS_EFLAG, 32'h3);
        wr(EPI_OFS_PFLAG, 32'h3);
        cpu_global_ie <= 1'b1;
        ext_irq_line_a <= 1'b0;
        ext_irq_line_b <= 1'b0;
        upper_group_pins <= ~upper_group_pins;
        lower_group_pins <= ~lower_group_pins;
        repeat (10) @(posedge aclk);
        chk("req", 34'hf, {30'h0, req});
        rd(EPI_OFS_CPU, 32'h1);
        wr(EPI_OFS_EMASK, 32'h0);
        repeat (4) @(posedge aclk);
        chk("req", 34'hc, {30'h0, req});
        wr(EPI_OFS_GEN, 32'h2);
        repeat (4) @(posedge aclk);
        chk("req", 34'h8, {30'h0, req});
        cpu_global_ie <= 1'b0;
        repeat (8) @(posedge aclk);
        chk("req", 34'h0, {30'h0, req});
        wr(EPI_OFS_GEN, 32'h3);
        wr(EPI_OFS_EMASK, 32'h3);
        cpu_global_ie <= 1'b1;
        take_en <= 1'b1;
        repeat (40) @(posedge aclk);
        chk("req", 34'h0, {30'h0, req});
        rd(EPI_OFS_EFLAG, 32'h0);
        rd(EPI_OFS_PFLAG, 32'h0);
        // Level mode requests while low, flags stay clear
        take_en <= 1'b0;
        wr(EPI_OFS_SENSE, 32'h0);
        repeat (6) @(posedge aclk);
        chk("req", 34'h3, {30'h0, req});
        rd(EPI_OFS_EFLAG, 32'h0);
        ext_irq_line_a <= 1'b1;
        ext_irq_line_b <= 1'b1;
        repeat (8) @(posedge aclk);
        chk("req", 34'h0, {30'h0, req});
        repeat (2) @(posedge aclk);
        tally_and_finish();
    end
endmodule : tb_top
